// file: scmc_pkg.sv
// Purpose: Shared constants and types of the system clock, reset and mode controller.
// Assumes: Controller logic runs on a 100 MHz core clock.
// Notes: Times are kept in nanoseconds; cycle counts are derived from them.
package scmc_pkg;
  localparam int CORE_CLK_NS = 10;
  localparam int POR_WAIT_NS = 4000000;
  localparam int XTAL_WAIT_NS = 1000000;
  localparam int POR_CYCLES = (POR_WAIT_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int XTAL_CYCLES = (XTAL_WAIT_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int WARM_HOLD_CYCLES = 8;
  localparam int WAKE_CYCLES = 4;
  localparam int DEAD_CYCLES = 2;
  localparam int WARM_SRCS = 6;
  localparam int UNITS = 32;
  localparam int PRE_DIV_W = 4;
  localparam int POST_DIV_W = 2;
  // Clock source select codes.
  localparam logic [1:0] SRC_RING = 2'h0;
  localparam logic [1:0] SRC_RC20 = 2'h1;
  localparam logic [1:0] SRC_XTAL = 2'h2;
  localparam logic [1:0] SRC_SYNTH = 2'h3;
  // Operating mode codes, shared by requests and the prior mode field.
  localparam logic [1:0] MODE_CODE_RUN = 2'h0;
  localparam logic [1:0] MODE_CODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_CODE_PDOWN = 2'h2;
  localparam logic [1:0] MODE_CODE_INIT = 2'h3;
  // Positions in the synchronised input vector.
  localparam int SYN_VDROP = 0;
  localparam int SYN_WAKE = 1;
  localparam int SYN_LOCK = 2;
  localparam int SYN_WARM = 3;
  typedef enum logic [2:0] {MODE_INIT, MODE_RUN, MODE_SLEEP, MODE_PDOWN, MODE_WAKE} scmc_mode_e;
  typedef enum logic [1:0] {SEL_HOLD, SEL_DEAD, SEL_SWITCH} scmc_sel_e;
endpackage

// file: scmc_glitchless_sel.sv
// Purpose: Glitch-free clock source selection as one-hot gate enables.
// Assumes: The gating cells downstream latch the enables on their own clocks.
// Notes: A change always passes through a dead interval with every enable low.
`timescale 1ns/1ps
module scmc_glitchless_sel #(
  parameter int NSRC = 4,
  parameter int DEAD = scmc_pkg::DEAD_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Selection
  input wire logic [1:0] sel_req_i,
  output logic [NSRC-1:0] src_en_o,
  output logic busy_o
);
  scmc_pkg::scmc_sel_e state;
  logic [1:0] cur_sel;
  logic [7:0] dead_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Break before make, so two clocks never overlap on the output.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= scmc_pkg::SEL_HOLD;
      cur_sel <= scmc_pkg::SRC_RING;
      dead_cnt <= 8'h00;
      src_en_o <= NSRC'(1);
    end
    else
    begin
      case (state)
        scmc_pkg::SEL_HOLD:
        begin
          if (sel_req_i != cur_sel)
          begin
            src_en_o <= '0;
            dead_cnt <= 8'(DEAD - 1);
            state <= scmc_pkg::SEL_DEAD;
          end
        end
        scmc_pkg::SEL_DEAD:
        begin
          if (dead_cnt == 8'h00)
          begin
            cur_sel <= sel_req_i;
            state <= scmc_pkg::SEL_SWITCH;
          end
          else
            dead_cnt <= dead_cnt - 8'h01;
        end
        scmc_pkg::SEL_SWITCH:
        begin
          src_en_o <= NSRC'(1) << cur_sel;
          state <= scmc_pkg::SEL_HOLD;
        end
        default: state <= scmc_pkg::SEL_HOLD;
      endcase
    end
  end

  assign busy_o = (state != scmc_pkg::SEL_HOLD);

  chk_mux_onehot: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $onehot0(src_en_o)) else $error("clock source enables not one-hot");
  chk_mux_break: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (src_en_o != $past(src_en_o)) |-> ($past(src_en_o) == '0 || src_en_o == '0))
    else $error("clock source switched without a dead interval");
endmodule

// file: scmc_unit_gate.sv
// Purpose: Per-unit clock gate enables derived from the peripheral master clock.
// Assumes: Enable vectors come from logic on the same clock.
// Notes: In sleep a unit keeps its clock only when its function is enabled too.
`timescale 1ns/1ps
module scmc_unit_gate #(
  parameter int N = scmc_pkg::UNITS
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic master_en_i,
  input wire logic sleep_i,
  input wire logic [N-1:0] clock_gate_i,
  input wire logic [N-1:0] function_en_i,
  // Gate enables
  output logic [N-1:0] unit_clock_en_o
);
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      unit_clock_en_o <= '0;
    else
      unit_clock_en_o <= {N{master_en_i}} & clock_gate_i
        & (~{N{sleep_i}} | function_en_i);
  end

  chk_gate_and: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    ##1 unit_clock_en_o == ($past({N{master_en_i}} & clock_gate_i)
      & (~{N{$past(sleep_i)}} | $past(function_en_i))))
    else $error("unit clock enable does not follow its gate bits");
endmodule

// file: scmc_top.sv
// Purpose: System clock selection, reset sequencing and operating mode control.
// Assumes: Sources and gating cells sit outside; this logic drives their enables.
// Notes: Pin-level events pass a three-stage synchroniser before use.
// Overview of operation
// - Clock source switches go through a dead interval, never producing glitches.
// - Main clock feeds core and bus; peripherals use it or an alternate.
// - Free core clock runs in every mode except power-down.
// - Bus clock stops while the processor is idle.
// - Peripheral master clock stops in power-down.
// - Each unit clock is the master clock gated by its gate bit.
// - After power-up the ring oscillator is on and selected.
// - Synthesizer takes either reference plus pre and post dividers.
// - Power-on holds processor reset for 4 ms, then starts.
// - Power-on flag sets on power-up and on voltage drop.
// - Cold reset returns the whole block to its initial state.
// - Enabled warm sources reset the system and record their cause.
// - Warm reset touches each unit only when its mask bit allows.
// - Core system reset spares the processor debug logic.
// - Reset holds init mode; init then passes to run mode.
// - Sleep stops the bus clock and units without function enable; enabled units keep clocks.
// - Power-down stops all circuits and leaves by wake-up.
// - Prior mode is recorded as run, sleep, power-down or init.
// - Standby pin marks power-down with a selectable polarity.
`timescale 1ns/1ps
module scmc_top #(
  parameter int NW = scmc_pkg::WARM_SRCS,
  parameter int NU = scmc_pkg::UNITS,
  parameter int POR_CYCLES = scmc_pkg::POR_CYCLES,
  parameter int XTAL_CYCLES = scmc_pkg::XTAL_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Clock source control
  input wire logic [1:0] clock_source_sel_i,
  input wire logic [1:0] periph_alt_sel_i,
  input wire logic rc20_enable_i,
  input wire logic crystal_enable_i,
  // Synthesizer control
  input wire logic synth_enable_i,
  input wire logic synth_ref_sel_i,
  input wire logic [scmc_pkg::PRE_DIV_W-1:0] synth_pre_div_i,
  input wire logic [scmc_pkg::POST_DIV_W-1:0] synth_post_div_i,
  input wire logic synth_lock_i,
  // Mode control
  input wire logic [1:0] mode_req_i,
  input wire logic mode_req_valid_i,
  input wire logic cpu_idle_i,
  input wire logic wake_event_i,
  input wire logic standby_out_polarity_i,
  // Reset control
  input wire logic vdrop_event_i,
  input wire logic [NW-1:0] warm_src_i,
  input wire logic [NW-1:0] reset_source_enable_i,
  input wire logic [NU-1:0] unit_reset_mask_i,
  input wire logic [NW:0] cause_clear_i,
  // Unit gating
  input wire logic [NU-1:0] unit_clock_gate_i,
  input wire logic [NU-1:0] unit_function_enable_i,
  // Source enables and status
  output logic [3:0] main_src_en_o,
  output logic main_sel_busy_o,
  output logic [3:0] periph_src_en_o,
  output logic ring_osc_en_o,
  output logic rc20_en_o,
  output logic crystal_en_o,
  output logic crystal_stable_o,
  output logic synth_en_o,
  output logic synth_ref_sel_o,
  output logic [scmc_pkg::PRE_DIV_W-1:0] synth_pre_div_o,
  output logic [scmc_pkg::POST_DIV_W-1:0] synth_post_div_o,
  output logic synth_locked_o,
  // Clock gates
  output logic free_core_clock_en_o,
  output logic bus_clock_en_o,
  output logic periph_master_en_o,
  output logic [NU-1:0] unit_clock_en_o,
  // Resets and state
  output logic core_system_reset_n_o,
  output logic debug_reset_n_o,
  output logic [NU-1:0] unit_reset_n_o,
  output logic [NW:0] reset_cause_o,
  output logic [1:0] prior_mode_field_o,
  output logic [1:0] mode_o,
  output logic standby_out_pin_o
);
  localparam int SW = scmc_pkg::SYN_WARM + NW;

  function automatic logic [1:0] mode_code(input scmc_pkg::scmc_mode_e m);
    case (m)
      scmc_pkg::MODE_RUN: mode_code = scmc_pkg::MODE_CODE_RUN;
      scmc_pkg::MODE_WAKE: mode_code = scmc_pkg::MODE_CODE_RUN;
      scmc_pkg::MODE_SLEEP: mode_code = scmc_pkg::MODE_CODE_SLEEP;
      scmc_pkg::MODE_PDOWN: mode_code = scmc_pkg::MODE_CODE_PDOWN;
      default: mode_code = scmc_pkg::MODE_CODE_INIT;
    endcase
  endfunction

  scmc_pkg::scmc_mode_e mode;
  scmc_pkg::scmc_mode_e next_mode;
  logic [SW-1:0] sync1, sync2, sync3, stable, stable_q, rise;
  logic [31:0] hold_cnt;
  logic [7:0] wake_cnt;
  logic [31:0] xtal_cnt;
  logic cold;
  logic warm_hit, vdrop_hit, wake_hit, reset_evt;
  logic [NW-1:0] warm_set;
  logic [1:0] main_sel_req;

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage synchroniser; a change counts once stages two and three agree.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end
    else
    begin
      sync1 <= {warm_src_i, synth_lock_i, wake_event_i, vdrop_event_i};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stable <= '0;
      stable_q <= '0;
    end
    else
    begin
      stable <= (sync2 & ~(sync2 ^ sync3)) | (stable & (sync2 ^ sync3));
      stable_q <= stable;
    end
  end

  assign rise = stable & ~stable_q;
  assign vdrop_hit = rise[scmc_pkg::SYN_VDROP];
  assign wake_hit = stable[scmc_pkg::SYN_WAKE];
  assign warm_set = rise[SW-1:scmc_pkg::SYN_WARM] & reset_source_enable_i;
  assign warm_hit = |warm_set;
  assign reset_evt = (warm_hit || vdrop_hit) && mode != scmc_pkg::MODE_INIT;

  ////////////////////////////////////////////////////////////////////////////
  // Operating mode sequencer.
  always_comb
  begin
    next_mode = mode;
    case (mode)
      scmc_pkg::MODE_INIT:
        if (hold_cnt == 32'h0) next_mode = scmc_pkg::MODE_RUN;
      scmc_pkg::MODE_RUN:
        if (mode_req_valid_i && mode_req_i == scmc_pkg::MODE_CODE_SLEEP)
          next_mode = scmc_pkg::MODE_SLEEP;
        else if (mode_req_valid_i && mode_req_i == scmc_pkg::MODE_CODE_PDOWN)
          next_mode = scmc_pkg::MODE_PDOWN;
      scmc_pkg::MODE_SLEEP, scmc_pkg::MODE_PDOWN:
        if (wake_hit) next_mode = scmc_pkg::MODE_WAKE;
      scmc_pkg::MODE_WAKE:
        if (wake_cnt == 8'h00) next_mode = scmc_pkg::MODE_RUN;
      default: next_mode = scmc_pkg::MODE_INIT;
    endcase
    if (reset_evt)
      next_mode = scmc_pkg::MODE_INIT;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mode <= scmc_pkg::MODE_INIT;
    else
      mode <= next_mode;
  end

  // Power-on hold counts the full interval; a warm reset uses a short one.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      hold_cnt <= 32'(POR_CYCLES - 1);
    else if (reset_evt)
      hold_cnt <= 32'(scmc_pkg::WARM_HOLD_CYCLES - 1);
    else if (mode == scmc_pkg::MODE_INIT && hold_cnt != 32'h0)
      hold_cnt <= hold_cnt - 32'h1;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wake_cnt <= 8'h00;
    else if (mode != scmc_pkg::MODE_WAKE)
      wake_cnt <= 8'(scmc_pkg::WAKE_CYCLES - 1);
    else if (wake_cnt != 8'h00)
      wake_cnt <= wake_cnt - 8'h01;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cold <= 1'b1;
    else if (mode == scmc_pkg::MODE_INIT && hold_cnt == 32'h0)
      cold <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset cause and prior mode; a set in the clearing cycle wins.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reset_cause_o <= {1'b1, {NW{1'b0}}};
    else
      reset_cause_o <= (reset_cause_o & ~cause_clear_i) | {vdrop_hit, warm_set};
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prior_mode_field_o <= scmc_pkg::MODE_CODE_INIT;
    else if (reset_evt)
      prior_mode_field_o <= mode_code(mode);
  end

  // Debug reset only follows the cold sequence, so warm resets spare it.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      core_system_reset_n_o <= 1'b0;
      debug_reset_n_o <= 1'b0;
      unit_reset_n_o <= '0;
    end
    else
    begin
      core_system_reset_n_o <= (next_mode != scmc_pkg::MODE_INIT);
      debug_reset_n_o <= debug_reset_n_o | ~cold;
      if (next_mode != scmc_pkg::MODE_INIT)
        unit_reset_n_o <= '1;
      else if (cold)
        unit_reset_n_o <= '0;
      else
        unit_reset_n_o <= ~unit_reset_mask_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gates and source enables. Wake brings peripherals back before the bus.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      free_core_clock_en_o <= 1'b1;
      bus_clock_en_o <= 1'b1;
      periph_master_en_o <= 1'b1;
      ring_osc_en_o <= 1'b1;
      rc20_en_o <= 1'b0;
      crystal_en_o <= 1'b0;
    end
    else
    begin
      free_core_clock_en_o <= (mode != scmc_pkg::MODE_PDOWN);
      bus_clock_en_o <= (mode == scmc_pkg::MODE_RUN || mode == scmc_pkg::MODE_INIT)
        && !cpu_idle_i;
      periph_master_en_o <= (mode != scmc_pkg::MODE_PDOWN);
      ring_osc_en_o <= (mode != scmc_pkg::MODE_PDOWN);
      rc20_en_o <= rc20_enable_i && mode != scmc_pkg::MODE_PDOWN && !cold;
      crystal_en_o <= crystal_enable_i && mode != scmc_pkg::MODE_PDOWN && !cold;
    end
  end

  // Divider values load only while the synthesizer is off, to avoid runt cycles.
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      synth_en_o <= 1'b0;
      synth_ref_sel_o <= 1'b0;
      synth_pre_div_o <= '0;
      synth_post_div_o <= '0;
      synth_locked_o <= 1'b0;
    end
    else
    begin
      synth_en_o <= synth_enable_i && mode != scmc_pkg::MODE_PDOWN && !cold;
      if (!synth_en_o)
      begin
        synth_ref_sel_o <= synth_ref_sel_i;
        synth_pre_div_o <= synth_pre_div_i;
        synth_post_div_o <= synth_post_div_i;
      end
      synth_locked_o <= synth_en_o && stable[scmc_pkg::SYN_LOCK];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      xtal_cnt <= 32'h0;
    else if (!crystal_en_o)
      xtal_cnt <= 32'h0;
    else if (xtal_cnt != 32'(XTAL_CYCLES))
      xtal_cnt <= xtal_cnt + 32'h1;
  end

  assign crystal_stable_o = (xtal_cnt == 32'(XTAL_CYCLES));

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      standby_out_pin_o <= 1'b1;
      mode_o <= scmc_pkg::MODE_CODE_INIT;
    end
    else
    begin
      standby_out_pin_o <= (mode == scmc_pkg::MODE_PDOWN) ~^ standby_out_polarity_i;
      mode_o <= mode_code(mode);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection and per-unit gating.
  assign main_sel_req = cold ? scmc_pkg::SRC_RING : clock_source_sel_i;

  scmc_glitchless_sel #(.NSRC(4), .DEAD(scmc_pkg::DEAD_CYCLES)) u_main_sel (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .sel_req_i(main_sel_req),
    .src_en_o(main_src_en_o),
    .busy_o(main_sel_busy_o)
  );

  // Alternate peripheral source; code zero means the main-derived clock.
  scmc_glitchless_sel #(.NSRC(4), .DEAD(scmc_pkg::DEAD_CYCLES)) u_periph_sel (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .sel_req_i(periph_alt_sel_i),
    .src_en_o(periph_src_en_o),
    .busy_o()
  );

  scmc_unit_gate #(.N(NU)) u_gate (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .master_en_i(periph_master_en_o),
    .sleep_i(mode == scmc_pkg::MODE_SLEEP),
    .clock_gate_i(unit_clock_gate_i),
    .function_en_i(unit_function_enable_i),
    .unit_clock_en_o(unit_clock_en_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_core_pd_stop: assert property (mode == scmc_pkg::MODE_PDOWN |=> !free_core_clock_en_o)
    else $error("free core clock enabled in power-down");
  chk_bus_idle_stop: assert property (cpu_idle_i |=> !bus_clock_en_o)
    else $error("bus clock running while processor idle");
  chk_periph_pd_stop: assert property (mode == scmc_pkg::MODE_PDOWN |=> !periph_master_en_o)
    else $error("peripheral master clock running in power-down");
  chk_init_to_run: assert property (mode == scmc_pkg::MODE_INIT && hold_cnt == 32'h0
    && !reset_evt |=> mode == scmc_pkg::MODE_RUN ##1 core_system_reset_n_o)
    else $error("init did not pass to run");
  chk_por_flag_set: assert property (vdrop_hit |=> reset_cause_o[NW])
    else $error("voltage drop did not set power-on flag");
  chk_warm_cause: assert property (warm_hit |=> (($past(warm_set)
    & ~reset_cause_o[NW-1:0]) == '0) && mode == scmc_pkg::MODE_INIT)
    else $error("warm reset cause not recorded");
  chk_unit_rst_mask: assert property (next_mode == scmc_pkg::MODE_INIT && !cold
    |=> unit_reset_n_o == ~$past(unit_reset_mask_i))
    else $error("unit reset ignores its mask");
  chk_debug_spared: assert property (debug_reset_n_o |=> debug_reset_n_o)
    else $error("debug reset reasserted by warm reset");
  chk_prior_mode: assert property (reset_evt |=> prior_mode_field_o == mode_code($past(mode)))
    else $error("prior mode not recorded");
  chk_standby_level: assert property (##1 standby_out_pin_o ==
    (($past(mode) == scmc_pkg::MODE_PDOWN) ~^ $past(standby_out_polarity_i)))
    else $error("standby pin level wrong");
  chk_wake_resume: assert property (mode == scmc_pkg::MODE_WAKE && !reset_evt
    |-> ##[1:4] mode == scmc_pkg::MODE_RUN)
    else $error("wake-up did not resume run mode");

  cov_sleep: cover property (mode == scmc_pkg::MODE_SLEEP);
  cov_pdown_wake: cover property (mode == scmc_pkg::MODE_PDOWN ##1 mode == scmc_pkg::MODE_WAKE);
  cov_warm_reset: cover property (reset_evt && mode == scmc_pkg::MODE_RUN);
endmodule

// file: test_system_clock_reset_mode_control.sv
// Purpose: Self-checking bench for the clock, reset and mode controller.
// Assumes: Inputs change on the falling edge; outputs are read there too.
// Notes: Short power-on and crystal counts keep the run brief.
`timescale 1ns/1ps
module test_system_clock_reset_mode_control;
  localparam int NW = 6;
  localparam int NU = 32;
  localparam int PORC = 20;
  localparam int XTC = 10;
  logic core_clk_i, rst_n_i = 1'h0;
  logic [1:0] clock_source_sel_i = 2'h0, periph_alt_sel_i = 2'h0, mode_req_i = 2'h0;
  logic rc20_enable_i = 0, crystal_enable_i = 0, synth_enable_i = 0, synth_ref_sel_i = 0;
  logic [3:0] synth_pre_div_i = 4'h0;
  logic [1:0] synth_post_div_i = 2'h0;
  logic synth_lock_i = 0, mode_req_valid_i = 0, cpu_idle_i = 0, wake_event_i = 0;
  logic standby_out_polarity_i = 0, vdrop_event_i = 0;
  logic [NW-1:0] warm_src_i = '0, reset_source_enable_i = '0;
  logic [NW:0] cause_clear_i = '0;
  logic [NU-1:0] unit_reset_mask_i = '0, unit_clock_gate_i = '0, unit_function_enable_i = '0;
  logic [3:0] main_src_en_o, periph_src_en_o;
  logic main_sel_busy_o, ring_osc_en_o, rc20_en_o, crystal_en_o, crystal_stable_o;
  logic synth_en_o, synth_ref_sel_o, synth_locked_o, free_core_clock_en_o;
  logic [3:0] synth_pre_div_o;
  logic [1:0] synth_post_div_o, prior_mode_field_o, mode_o;
  logic bus_clock_en_o, periph_master_en_o, core_system_reset_n_o, debug_reset_n_o;
  logic standby_out_pin_o;
  logic [NU-1:0] unit_clock_en_o, unit_reset_n_o;
  logic [NW:0] reset_cause_o;
  int bad_count = 0, n_checks = 0, cycles = 0, k;
  logic [3:0] old;
  logic [1:0] c;

  scmc_top #(.POR_CYCLES(PORC), .XTAL_CYCLES(XTC)) i_scmc_top (.*);

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk_i = 1'h0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // A hang is cut short here; a quiet design must not hold the run forever.
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wait_mode(input logic [1:0] m);
    int i;
    i = 0;
    while (mode_o !== m && i < 40)
    begin
      cyc(1);
      i++;
    end
    chk("mode_o", mode_o, m);
  endtask

  task automatic req(input logic [1:0] m);
    mode_req_i = m;
    mode_req_valid_i = 1'h1;
    cyc(1);
    mode_req_valid_i = 1'h0;
    cyc(3);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(49078));
    cyc(10);
    chk("main_src_en_o", main_src_en_o, 4'h1);
    chk("ring_osc_en_o", ring_osc_en_o, 1'h1);
    chk("reset_cause_o", reset_cause_o, 7'h40);
    chk("prior_mode", prior_mode_field_o, 2'h3);
    chk("core_rst", core_system_reset_n_o, 1'h0);
    rst_n_i = 1'h1;
    cyc(PORC / 2);
    chk("mode_o", mode_o, 2'h3);
    chk("core_rst", core_system_reset_n_o, 1'h0);
    wait_mode(2'h0);
    cyc(1);
    chk("core_rst", core_system_reset_n_o, 1'h1);
    $display("test power-on done");
    // Every source is visited; the enables may never show two sources at once.
    // Crystal pins count as muxed here, and flash waits sit outside this block.
    rc20_enable_i = 1'h1;
    crystal_enable_i = 1'h1;
    synth_enable_i = 1'h1;
    synth_lock_i = 1'h1;
    cyc(3);
    chk("crystal_stable", crystal_stable_o, 1'h0);
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i + 2);
      old = main_src_en_o;
      clock_source_sel_i = c;
      repeat (8)
      begin
        cyc(1);
        chk("src_en_extra", main_src_en_o & ~(old | (4'h1 << c)), 4'h0);
        chk("src_en_one", 32'($countones(main_src_en_o) <= 1), 32'h1);
      end
      chk("main_src_en_o", main_src_en_o, 4'h1 << c);
    end
    chk("crystal_stable", crystal_stable_o, 1'h1);
    chk("synth_locked", synth_locked_o, 1'h1);
    $display("test clock select done");
    unit_clock_gate_i = $urandom;
    unit_function_enable_i = $urandom;
    cpu_idle_i = 1'h1;
    cyc(3);
    chk("unit_clock_en", unit_clock_en_o, unit_clock_gate_i);
    chk("bus_clock_en", bus_clock_en_o, 1'h0);
    chk("free_core_en", free_core_clock_en_o, 1'h1);
    cpu_idle_i = 1'h0;
    req(2'h1);
    chk("mode_o", mode_o, 2'h1);
    chk("unit_clock_en", unit_clock_en_o, unit_clock_gate_i & unit_function_enable_i);
    chk("free_core_en", free_core_clock_en_o, 1'h1);
    wake_event_i = 1'h1;
    wait_mode(2'h0);
    cyc(8);
    wake_event_i = 1'h0;
    cyc(6);
    standby_out_polarity_i = 1'($urandom);
    req(2'h2);
    chk("mode_o", mode_o, 2'h2);
    chk("free_core_en", free_core_clock_en_o, 1'h0);
    chk("periph_master", periph_master_en_o, 1'h0);
    chk("standby", standby_out_pin_o, standby_out_polarity_i);
    wake_event_i = 1'h1;
    wait_mode(2'h0);
    cyc(8);
    chk("free_core_en", free_core_clock_en_o, 1'h1);
    chk("standby", standby_out_pin_o, !standby_out_polarity_i);
    wake_event_i = 1'h0;
    cyc(6);
    $display("test modes done");
    // A disabled source is pulsed first; only the enabled one may act.
    repeat (3)
    begin
      k = $urandom_range(0, NW - 1);
      reset_source_enable_i = NW'(1) << k;
      unit_reset_mask_i = $urandom;
      cause_clear_i = '1;
      cyc(1);
      cause_clear_i = '0;
      warm_src_i = NW'(1) << ((k + 1) % NW);
      cyc(8);
      chk("reset_cause", reset_cause_o, 7'h0);
      chk("core_rst", core_system_reset_n_o, 1'h1);
      warm_src_i = NW'(1) << k;
      cyc(7);
      chk("reset_cause", reset_cause_o, 7'h1 << k);
      chk("core_rst", core_system_reset_n_o, 1'h0);
      chk("debug_rst", debug_reset_n_o, 1'h1);
      chk("unit_rst", unit_reset_n_o, ~unit_reset_mask_i);
      chk("prior_mode", prior_mode_field_o, 2'h0);
      warm_src_i = '0;
      wait_mode(2'h0);
      cyc(1);
      chk("unit_rst", unit_reset_n_o, '1);
    end
    vdrop_event_i = 1'h1;
    cyc(7);
    chk("vdrop_flag", reset_cause_o[NW], 1'h1);
    vdrop_event_i = 1'h0;
    wait_mode(2'h0);
    $display("test warm reset done");
    tally_and_finish();
  end
endmodule
